// File: rtl/csd_device.sv
// device end: chopped sinc3 decimator with its serial register port
// assumes modulator clock and bit arrive asynchronously, bit stable at clock rise
`timescale 1ns/10ps
`include "csd_regs.svh"
module csd_device
    import csd_pkg::*;
(
    input wire logic ref_clk, // 20 MHz system clock
    input wire logic rst, // synchronous reset, active high
    csd_link_if.dev_mp link, // serial link to host
    input wire logic mod_clk, // modulator clock
    input wire logic mod_bit, // modulator comparator bit
    output logic chop_out, // input reversal phase
    output logic [15:0] result, // last data register value
    output logic result_stb // one-cycle pulse on new result
);

    csd_dev_state_t s_reg;
    csd_dev_state_t s_next;
    logic mod_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic x_bit;
    logic [10:0] dec_len;
    logic [35:0] d1;
    logic [35:0] d2;
    logic [35:0] d3;
    logic [36:0] sum;
    logic [35:0] scaled;
    logic [4:0] sh;
    logic [15:0] sat;
    logic published;
    logic [7:0] cmd_byte;
    logic [15:0] wr_word;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic csd_dev_state_t dev_reset();
        csd_dev_state_t r;
        r = '0;
        r.sf = `CSD_SF_RESET;
        r.rdy_n = 1'b1;
        r.cs_s = 2'b11;
        r.sclk_s = 2'b11;
        r.sclk_prev = 1'b1;
        r.phase = CSD_SP_CMD;
        r.left = 5'h07;
        return r;
    endfunction

    function automatic logic [4:0] ceil_log2(input logic [10:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 11; i++)
        begin
            if ((11'h001 << i) < v)
            begin
                r = 5'(i + 1);
            end
        end
        return r;
    endfunction

    function automatic logic [4:0] reg_len(input logic [1:0] a);
        return (a == `CSD_ADDR_DATA) ? 5'h10 : 5'h08;
    endfunction

    function automatic csd_dev_state_t restart(input csd_dev_state_t v);
        csd_dev_state_t r;
        r = v;
        r.tick = '0;
        r.dec = '0;
        r.chop = 1'b0;
        r.i1 = '0;
        r.i2 = '0;
        r.i3 = '0;
        r.z1 = '0;
        r.z2 = '0;
        r.z3 = '0;
        r.prev = '0;
        r.have_prev = 1'b0;
        r.rdy_n = 1'b1;
        return r;
    endfunction

    // ----------------------------------------------------------------
    // datapath terms
    // ----------------------------------------------------------------
    assign mod_rise = s_reg.mod_clk_s[1] & ~s_reg.mod_prev;
    assign sclk_rise = s_reg.sclk_s[1] & ~s_reg.sclk_prev & ~s_reg.cs_s[1];
    assign sclk_fall = ~s_reg.sclk_s[1] & s_reg.sclk_prev & ~s_reg.cs_s[1];
    assign x_bit = s_reg.mod_bit_s[1] ^ s_reg.chop;
    assign dec_len = {s_reg.sf, 3'b000};
    assign d1 = s_reg.i3 - s_reg.z1;
    assign d2 = d1 - s_reg.z2;
    assign d3 = d2 - s_reg.z3;
    assign sum = {1'b0, d3} + {1'b0, s_reg.prev};
    // ceiling log keeps full scale above 13 bits and at or under 16 bits
    assign sh = 5'(3 * ceil_log2(dec_len) - `CSD_OUT_BITS);
    assign scaled = sum[36:1] >> sh;
    assign sat = (|scaled[35:16]) ? 16'hFFFF : scaled[15:0];
    assign cmd_byte = {s_reg.shin[6:0], s_reg.din_s[1]};
    assign wr_word = {s_reg.shin[14:0], s_reg.din_s[1]};

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        published = 1'b0;
        s_next.mod_clk_s = {s_reg.mod_clk_s[0], mod_clk};
        s_next.mod_bit_s = {s_reg.mod_bit_s[0], mod_bit};
        s_next.sclk_s = {s_reg.sclk_s[0], link.sclk};
        s_next.cs_s = {s_reg.cs_s[0], link.cs_n};
        s_next.din_s = {s_reg.din_s[0], link.din};
        s_next.mod_prev = s_reg.mod_clk_s[1];
        s_next.sclk_prev = s_reg.sclk_s[1];
        s_next.dout_oe = ~s_reg.cs_s[1];
        s_next.new_stb = 1'b0;

        // sinc3: one integrator step per modulator clock, three combs per decimation
        if (mod_rise)
        begin
            s_next.i1 = s_reg.i1 + {35'h0, x_bit};
            s_next.i2 = s_reg.i2 + s_reg.i1;
            s_next.i3 = s_reg.i3 + s_reg.i2;
            if (s_reg.tick == dec_len - 11'h001)
            begin
                s_next.tick = '0;
                s_next.z1 = s_reg.i3;
                s_next.z2 = d1;
                s_next.z3 = d2;
                // three decimations per result: period is 24 clocks per word step
                if (s_reg.dec == `CSD_LAST_DEC)
                begin
                    s_next.dec = '0;
                    s_next.chop = ~s_reg.chop;
                    s_next.prev = d3;
                    s_next.have_prev = 1'b1;
                    if (s_reg.have_prev)
                    begin
                        s_next.data = sat;
                        s_next.rdy_n = 1'b0;
                        s_next.new_stb = 1'b1;
                        published = 1'b1;
                    end
                end
                else
                begin
                    s_next.dec = s_reg.dec + 2'h1;
                end
            end
            else
            begin
                s_next.tick = s_reg.tick + 11'h001;
                if (s_reg.dec == `CSD_LAST_DEC &&
                    s_reg.tick >= dec_len - `CSD_RDY_LEAD - 11'h001)
                begin
                    s_next.rdy_n = 1'b1;
                end
            end
        end

        // output shifter moves on the falling edge so the host samples at the end of the high phase
        if (sclk_fall && s_reg.phase == CSD_SP_RD)
        begin
            s_next.dout = s_reg.shout[15];
            s_next.shout = {s_reg.shout[14:0], 1'b0};
        end

        // edges are counted only while selected, so bursts keep their place
        if (sclk_rise)
        begin
            s_next.ones = s_reg.din_s[1] ? s_reg.ones + 6'h01 : 6'h00;
            unique case (s_reg.phase)
                CSD_SP_CMD:
                begin
                    // a leading one holds the port at the first bit
                    if (!(s_reg.left == 5'h07 && s_reg.din_s[1]))
                    begin
                        s_next.shin = wr_word;
                        s_next.left = s_reg.left - 5'h01;
                        if (s_reg.left == 5'h00)
                        begin
                            s_next.addr = cmd_byte[1:0];
                            s_next.left = reg_len(cmd_byte[1:0]) - 5'h01;
                            if (cmd_byte[1:0] == `CSD_ADDR_COMM)
                            begin
                                s_next.left = 5'h07;
                            end
                            else if (cmd_byte[`CSD_CMD_RW])
                            begin
                                s_next.phase = CSD_SP_RD;
                                unique case (cmd_byte[1:0])
                                    `CSD_ADDR_FILTER: s_next.shout = {s_reg.sf, 8'h00};
                                    `CSD_ADDR_DATA: s_next.shout = s_reg.data;
                                    default: s_next.shout = 16'h0000;
                                endcase
                            end
                            else
                            begin
                                s_next.phase = CSD_SP_WR;
                            end
                        end
                    end
                end
                CSD_SP_WR:
                begin
                    s_next.shin = wr_word;
                    s_next.left = s_reg.left - 5'h01;
                    if (s_reg.left == 5'h00)
                    begin
                        s_next.phase = CSD_SP_CMD;
                        s_next.left = 5'h07;
                        // out-of-range words are dropped and the old setting stays
                        if (s_reg.addr == `CSD_ADDR_FILTER && wr_word[7:0] >= `CSD_SF_MIN)
                        begin
                            s_next = restart(s_next);
                            s_next.sf = wr_word[7:0];
                        end
                    end
                end
                CSD_SP_RD:
                begin
                    s_next.left = s_reg.left - 5'h01;
                    if (s_reg.left == 5'h00)
                    begin
                        s_next.phase = CSD_SP_CMD;
                        s_next.left = 5'h07;
                        // a result landing in this cycle keeps ready low
                        if (s_reg.addr == `CSD_ADDR_DATA && !published)
                        begin
                            s_next.rdy_n = 1'b1;
                        end
                    end
                end
            endcase
            if (s_reg.din_s[1] && s_reg.ones == `CSD_SYNC_ONES - 6'h01)
            begin
                s_next = dev_reset();
                s_next.mod_clk_s = {s_reg.mod_clk_s[0], mod_clk};
                s_next.mod_bit_s = {s_reg.mod_bit_s[0], mod_bit};
                s_next.sclk_s = {s_reg.sclk_s[0], link.sclk};
                s_next.cs_s = {s_reg.cs_s[0], link.cs_n};
                s_next.din_s = {s_reg.din_s[0], link.din};
                s_next.mod_prev = s_reg.mod_clk_s[1];
                s_next.sclk_prev = s_reg.sclk_s[1];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_reg <= dev_reset();
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign link.dout = s_reg.dout;
    assign link.dout_oe = s_reg.dout_oe;
    assign link.rdy_n = s_reg.rdy_n;
    assign chop_out = s_reg.chop;
    assign result = s_reg.data;
    assign result_stb = s_reg.new_stb;

endmodule

// File: rtl/csd_host.sv
// host end: serial master that writes, reads and resynchronises the device
// assumes the device samples data in on serial clock rise and idles high
`timescale 1ns/10ps
`include "csd_regs.svh"
module csd_host
    import csd_pkg::*;
#(
    parameter logic [7:0] SCLK_HALF = 8'(`CSD_SCLK_HALF)
)
(
    input wire logic ref_clk, // 20 MHz system clock
    input wire logic rst, // synchronous reset, active high
    csd_link_if.host_mp link, // serial link to device
    input wire logic cmd_valid, // request present
    input wire logic cmd_write, // 1 write, 0 read
    input wire logic cmd_sync, // send 32 ones instead
    input wire logic [1:0] cmd_addr, // register selection
    input wire logic [15:0] cmd_wdata, // write data, low byte for 8-bit
    output logic cmd_ready, // request can be taken
    output logic rsp_valid, // one-cycle pulse at end of access
    output logic [15:0] rsp_rdata // read data; for writes, the data out samples taken during the access
);

    csd_host_state_t s_reg;
    csd_host_state_t s_next;
    logic wide_req;
    logic [7:0] cmd_byte;

    assign wide_req = (cmd_addr == `CSD_ADDR_DATA);
    assign cmd_byte = {1'b0, ~cmd_write, 4'h0, cmd_addr};

    always_comb
    begin
        s_next = s_reg;
        s_next.rdy_s = {s_reg.rdy_s[0], link.rdy_n};
        s_next.dout_s = {s_reg.dout_s[0], link.dout_line};
        s_next.rsp_valid = 1'b0;
        unique case (s_reg.phase)
            CSD_H_IDLE:
            begin
                if (cmd_valid && s_reg.cmd_ready)
                begin
                    s_next.cmd_ready = 1'b0;
                    s_next.wide = wide_req;
                    s_next.first = 1'b1;
                    s_next.div = 8'h00;
                    s_next.rx = 16'h0000;
                    if (cmd_sync)
                    begin
                        s_next.tx = 32'hFFFF_FFFF;
                        s_next.nbits = 6'h20;
                        s_next.phase = CSD_H_XFER;
                    end
                    else
                    begin
                        s_next.tx = {cmd_byte, wide_req ? cmd_wdata : {cmd_wdata[7:0], 8'h00},
                                     8'h00};
                        if (!cmd_write)
                        begin
                            s_next.tx[23:8] = 16'h0000;
                        end
                        s_next.nbits = wide_req ? 6'h18 : 6'h10;
                        // a data read waits for ready so it never straddles an update
                        s_next.phase = (!cmd_write && wide_req) ? CSD_H_WAIT : CSD_H_XFER;
                    end
                end
            end
            CSD_H_WAIT:
            begin
                if (!s_reg.rdy_s[1])
                begin
                    s_next.phase = CSD_H_XFER;
                end
            end
            CSD_H_XFER:
            begin
                s_next.cs_n = 1'b0;
                s_next.div = s_reg.div + 8'h01;
                if (s_reg.div == SCLK_HALF - 8'h01)
                begin
                    s_next.div = 8'h00;
                    if (s_reg.sclk)
                    begin
                        // end of high phase: the device output is settled here
                        s_next.first = 1'b0;
                        if (!s_reg.first)
                        begin
                            s_next.rx = {s_reg.rx[14:0], s_reg.dout_s[1]};
                        end
                        if (s_reg.nbits == 6'h00)
                        begin
                            s_next.phase = CSD_H_IDLE;
                            s_next.cs_n = 1'b1;
                            s_next.cmd_ready = 1'b1;
                            s_next.rsp_valid = 1'b1;
                            s_next.rsp_rdata = s_reg.wide ? s_next.rx : {8'h00, s_next.rx[7:0]};
                        end
                        else
                        begin
                            s_next.sclk = 1'b0;
                            s_next.din = s_reg.tx[31];
                            s_next.tx = {s_reg.tx[30:0], 1'b0};
                            s_next.nbits = s_reg.nbits - 6'h01;
                        end
                    end
                    else
                    begin
                        s_next.sclk = 1'b1;
                    end
                end
            end
            default:
            begin
                s_next.phase = CSD_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_reg <= '{phase: CSD_H_IDLE, sclk: 1'b1, cs_n: 1'b1, rdy_s: 2'b11,
                       dout_s: 2'b11, cmd_ready: 1'b1, default: '0};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign link.sclk = s_reg.sclk;
    assign link.cs_n = s_reg.cs_n;
    assign link.din = s_reg.din;
    assign cmd_ready = s_reg.cmd_ready;
    assign rsp_valid = s_reg.rsp_valid;
    assign rsp_rdata = s_reg.rsp_rdata;

endmodule

// File: rtl/csd_link_if.sv
// serial link between the converter back end and its host
// assumes an idle-high data out line when the device does not drive it
`timescale 1ns/10ps
interface csd_link_if;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout;
    logic dout_oe;
    logic rdy_n;
    logic dout_line;

    // weak pull-up stands in for the undriven line
    assign dout_line = dout_oe ? dout : 1'b1;

    modport dev_mp (input sclk, input cs_n, input din, output dout, output dout_oe,
                    output rdy_n);
    modport host_mp (output sclk, output cs_n, output din, input dout_line, input rdy_n);
endinterface

// File: rtl/csd_pkg.sv
// types shared by both ends of the chopped sinc3 decimator link
// assumes nothing beyond a SystemVerilog compiler
package csd_pkg;

    typedef enum logic [1:0] {CSD_SP_CMD, CSD_SP_WR, CSD_SP_RD} csd_ser_phase_t;
    typedef enum logic [1:0] {CSD_H_IDLE, CSD_H_WAIT, CSD_H_XFER} csd_host_phase_t;

    typedef struct packed {
        logic [1:0] mod_clk_s;
        logic [1:0] mod_bit_s;
        logic [1:0] sclk_s;
        logic [1:0] cs_s;
        logic [1:0] din_s;
        logic mod_prev;
        logic sclk_prev;
        logic [7:0] sf;
        logic chop;
        logic [10:0] tick;
        logic [1:0] dec;
        logic [35:0] i1;
        logic [35:0] i2;
        logic [35:0] i3;
        logic [35:0] z1;
        logic [35:0] z2;
        logic [35:0] z3;
        logic [35:0] prev;
        logic have_prev;
        logic [15:0] data;
        logic new_stb;
        logic rdy_n;
        csd_ser_phase_t phase;
        logic [4:0] left;
        logic [15:0] shin;
        logic [15:0] shout;
        logic [1:0] addr;
        logic [5:0] ones;
        logic dout;
        logic dout_oe;
    } csd_dev_state_t;

    typedef struct packed {
        csd_host_phase_t phase;
        logic [7:0] div;
        logic sclk;
        logic cs_n;
        logic din;
        logic first;
        logic [31:0] tx;
        logic [5:0] nbits;
        logic [15:0] rx;
        logic wide;
        logic [1:0] rdy_s;
        logic [1:0] dout_s;
        logic cmd_ready;
        logic rsp_valid;
        logic [15:0] rsp_rdata;
    } csd_host_state_t;

endpackage

// File: rtl/csd_regs.svh
// constants shared by both ends of the chopped sinc3 decimator link
// assumes inclusion by bare name after the package or in a module body
`ifndef CSD_REGS_SVH
`define CSD_REGS_SVH

// ----------------------------------------------------------------
// register selection
// ----------------------------------------------------------------
`define CSD_ADDR_COMM 2'h0
`define CSD_ADDR_FILTER 2'h1
`define CSD_ADDR_DATA 2'h2
`define CSD_ADDR_SPARE 2'h3

// ----------------------------------------------------------------
// command byte fields
// ----------------------------------------------------------------
`define CSD_CMD_WEN 7
`define CSD_CMD_RW 6

// ----------------------------------------------------------------
// filter settings
// ----------------------------------------------------------------
`define CSD_SF_RESET 8'h45
`define CSD_SF_MIN 8'h0D
`define CSD_SF_MAX 8'hFF
`define CSD_DEC_SHIFT 3
`define CSD_LAST_DEC 2'h2
`define CSD_RDY_LEAD 11'h004
`define CSD_OUT_BITS 16
`define CSD_MOD_RATE_HZ 32768

// ----------------------------------------------------------------
// link timing
// ----------------------------------------------------------------
`define CSD_SYNC_ONES 6'h20
`define CSD_REF_PERIOD_NS 50
`define CSD_SCLK_PERIOD_NS 400
`define CSD_SCLK_HALF (`CSD_SCLK_PERIOD_NS / (2 * `CSD_REF_PERIOD_NS))

`endif

// File: testbench/csd_link_monitor.sv
// checker for the serial link joining the two ends
// assumes it sits beside the link interface, one reference clock domain
`timescale 1ns/10ps
module csd_link_monitor (
    input wire logic ref_clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic sclk, // serial clock
    input wire logic cs_n, // select, active low
    input wire logic dout, // device data
    input wire logic dout_oe, // device drive enable
    input wire logic rdy_n // data ready, active low
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // serial clock phases
    // ------------------------------------------------------------
    sequence s_low_phase;
        !sclk [*4];
    endsequence
    sequence s_high_phase;
        sclk [*4];
    endsequence
    a_low_phase_len: assert property ($fell(sclk) |-> s_low_phase)
        else $error("serial clock low phase too short");
    a_high_phase_len: assert property ($rose(sclk) |-> s_high_phase)
        else $error("serial clock high phase too short");
    a_edges_selected: assert property ($fell(sclk) |-> !cs_n)
        else $error("serial clock toggled while deselected");
    a_idle_level: assert property (cs_n |-> sclk)
        else $error("serial clock not idle high while deselected");
    // ------------------------------------------------------------
    // device outputs
    // ------------------------------------------------------------
    a_ready_after_reset: assert property ($fell(rst) |-> rdy_n && !dout_oe)
        else $error("ready or drive active after reset");
    a_dout_steady: assert property (dout_oe && sclk && $past(sclk) |-> $stable(dout))
        else $error("data out moved during clock high");
    // sync lag allows a few cycles before the driver lets go
    a_no_drive_idle: assert property (cs_n [*5] |-> !dout_oe)
        else $error("data out driven while deselected");
    a_ready_hold: assert property ($fell(rdy_n) |-> !rdy_n [*8])
        else $error("ready pulse too short");
endmodule

// File: testbench/testbench.sv
// self-checking bench: host and device joined by the link
// assumes a fast modulator clock of 400 ns so results come every 2496 cycles at filter word 0x0D
`timescale 1ns/10ps
module testbench;
    import csd_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic mod_clk = 1'b0;
    logic mod_bit;
    logic chop_out;
    logic [15:0] result;
    logic result_stb;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic cmd_sync = 1'b0;
    logic [1:0] cmd_addr = 2'h0;
    logic [15:0] cmd_wdata = 16'h0000;
    logic cmd_ready;
    logic rsp_valid;
    logic [15:0] rsp_rdata;
    logic [15:0] rd;
    logic chop_old;
    logic step = 1'b0;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int stb_at = 0;
    int gap = 0;
    csd_link_if link_i();
    csd_device csd_device_i (.ref_clk(ref_clk), .rst(rst), .link(link_i), .mod_clk(mod_clk),
        .mod_bit(mod_bit), .chop_out(chop_out), .result(result), .result_stb(result_stb));
    csd_host csd_host_i (.ref_clk(ref_clk), .rst(rst), .link(link_i), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_sync(cmd_sync), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata));
    csd_link_monitor csd_link_monitor_i (.ref_clk(ref_clk), .rst(rst), .sclk(link_i.sclk),
        .cs_n(link_i.cs_n), .dout(link_i.dout), .dout_oe(link_i.dout_oe), .rdy_n(link_i.rdy_n));
    always #25 ref_clk = ~ref_clk;
    always #200 mod_clk = ~mod_clk;
    // bit follows inverted chop: the filter sees all ones, then all zeros once step rises
    assign mod_bit = ~chop_out ^ step;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic op(input logic wr, input logic sy, input logic [1:0] a, input logic [15:0] wd);
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_sync = sy;
        cmd_addr = a;
        cmd_wdata = wd;
        do @(posedge ref_clk); while (cmd_ready !== 1'b1);
        #1;
        cmd_valid = 1'b0;
        do @(posedge ref_clk); while (rsp_valid !== 1'b1);
        rd = rsp_rdata;
    endtask
    task automatic wait_stb;
        chop_old = chop_out;
        do @(posedge ref_clk); while (result_stb !== 1'b1);
        gap = int'($time / 50) - stb_at;
        stb_at = int'($time / 50);
        #1;
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_count++;
            complete_run();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge ref_clk);
        check({15'h0000, link_i.rdy_n}, 16'h0001);
        op(1'b0, 1'b0, 2'h1, 16'h0000);
        check(rd, 16'h0045);
        op(1'b1, 1'b0, 2'h1, 16'h000C);
        op(1'b0, 1'b0, 2'h1, 16'h0000);
        check(rd, 16'h0045);
        op(1'b1, 1'b0, 2'h1, 16'h000D);
        stb_at = int'($time / 50);
        op(1'b0, 1'b0, 2'h1, 16'h0000);
        check(rd, 16'h000D);
        wait_stb();
        check({15'h0000, gap > 4944 && gap < 5040}, 16'h0001);
        wait_stb();
        check(16'(gap), 16'(3 * 8 * 13 * 8));
        check({15'h0000, chop_out ^ chop_old}, 16'h0001);
        check({15'h0000, link_i.rdy_n}, 16'h0000);
        // 104 cubed shifted by 3*7-16
        op(1'b0, 1'b0, 2'h2, 16'h0000);
        check(rd, 16'((104 * 104 * 104) >> 5));
        check({15'h0000, link_i.rdy_n}, 16'h0001);
        wait_stb();
        repeat (2496 - 20 - 1) @(posedge ref_clk);
        check({15'h0000, link_i.rdy_n}, 16'h0001);
        wait_stb();
        check(16'(gap), 16'(2496));
        // step mid-period: the second result still carries it, the third is settled
        repeat (1000) @(posedge ref_clk);
        #1;
        step = 1'b1;
        wait_stb();
        wait_stb();
        check({15'h0000, result != 16'h0000}, 16'h0001);
        wait_stb();
        check(result, 16'h0000);
        op(1'b0, 1'b1, 2'h0, 16'h0000);
        op(1'b0, 1'b0, 2'h1, 16'h0000);
        check(rd, 16'h0045);
        op(1'b1, 1'b0, 2'h1, 16'h00FF);
        op(1'b0, 1'b0, 2'h1, 16'h0000);
        check(rd, 16'h00FF);
        #1;
        rst = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        op(1'b0, 1'b0, 2'h1, 16'h0000);
        check(rd, 16'h0045);
        complete_run();
    end
endmodule
